// file: chgrb_consts.svh
// chgrb_consts.svh: constants of the charger control register bank
// assumes: included by bare name wherever a constant is needed
`ifndef CHGRB_CONSTS_SVH
`define CHGRB_CONSTS_SVH
`define CHGRB_DEV_ADDR 7'h69
`define CHGRB_ADDR_WR 8'hd2
`define CHGRB_ADDR_RD 8'hd3
`define CHGRB_REG_FIRST 8'h01
`define CHGRB_REG_LAST 8'h0a
`define CHGRB_OFF_SYSCTL 4'h1
`define CHGRB_OFF_VOLT 4'h2
`define CHGRB_OFF_CURR 4'h3
`define CHGRB_OFF_SET1 4'h4
`define CHGRB_OFF_SET2 4'h5
`define CHGRB_OFF_TEMPW 4'h6
`define CHGRB_OFF_LOOP 4'h7
`define CHGRB_OFF_FAULT 4'h8
`define CHGRB_OFF_FLAGS 4'h9
`define CHGRB_OFF_MASK 4'ha
`define CHGRB_RST_SYSCTL 8'h3b
`define CHGRB_RST_VOLT 8'h01
`define CHGRB_RST_CURR 8'h4a
`define CHGRB_RST_SET1 8'h0a
`define CHGRB_RST_SET2 8'h55
`define CHGRB_RST_TEMPW 8'h97
`define CHGRB_RST_MASK 8'h00
`define CHGRB_BIT_TWIN 5
`define CHGRB_BIT_CHG 4
`define CHGRB_BIT_TIMER 3
`define CHGRB_BIT_TERM 1
`define CHGRB_BIT_TLOOP 0
`define CHGRB_BIT_RECHG 4
`define CHGRB_INT_PULSE_US 456
`define CHGRB_CLK_MHZ 25
`define CHGRB_INT_CYCLES ((`CHGRB_INT_PULSE_US) * (`CHGRB_CLK_MHZ))
`define CHGRB_INT_CNT_W 14
`define CHGRB_BYTE_LAST 3'h7
`define CHGRB_ZERO8 8'h00
`endif

// file: chgrb_pkg.sv
// chgrb_pkg.sv: types of the charger control register bank
// assumes: nothing
package chgrb_pkg;
  typedef enum logic [2:0]
  {
    CHGRB_IDLE = 3'b000,
    CHGRB_ADDR = 3'b001,
    CHGRB_AACK = 3'b010,
    CHGRB_WBYTE = 3'b011,
    CHGRB_WACK = 3'b100,
    CHGRB_RBYTE = 3'b101,
    CHGRB_RACK = 3'b110
  } chgrb_state_type;
endpackage : chgrb_pkg

// file: chgrb_int_pulse.sv
// chgrb_int_pulse.sv: interrupt pulse stretcher, drives the active low int pin
// assumes: one mclk domain, trig is a one-cycle pulse
`timescale 1ns/1ps
`include "chgrb_consts.svh"
module chgrb_int_pulse
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic trig,
  output logic int_n
);
  typedef struct packed
  {
    logic [`CHGRB_INT_CNT_W-1:0] cnt;
    logic active;
  } chgrb_pulse_type;
  chgrb_pulse_type st_reg;
  chgrb_pulse_type st_next;
  always_comb
  begin
    st_next = st_reg;
    if (trig)
    begin
      st_next.active = 1'b1;
      st_next.cnt = `CHGRB_INT_CNT_W'(`CHGRB_INT_CYCLES - 1);
    end
    else if (st_reg.active)
    begin
      if (st_reg.cnt == '0)
        st_next.active = 1'b0;
      else
        st_next.cnt = st_reg.cnt - 1'b1;
    end
  end
  always_ff @(posedge mclk)
  begin
    if (srst)
      st_reg <= '0;
    else if (clk_en)
      st_reg <= st_next;
  end
  assign int_n = ~st_reg.active;
  a_pulse_low_start: assert property (@(posedge mclk) disable iff (srst)
    (clk_en && trig) |=> !int_n)
    else $error("int pin not low after trigger");
endmodule : chgrb_int_pulse

// file: chgrb_bank.sv
// chgrb_bank.sv: i2c target and register bank of a buck charger
// assumes: scl/sda sampled synchronously on mclk, open-drain sda as in/out/oe
// Behaviour
// RULE_01 - answer as i2c target at 7-bit address 0x69, write 0xd2, read 0xd3
// RULE_02 - system control bit 4 enables charging, resets to 1
// RULE_03 - system control bit 3 enables the safety timer, resets to 1
// RULE_04 - system control bit 1 selects automatic termination, resets to 1
// RULE_05 - system control bit 0 enables junction temperature loop, resets to 1
// RULE_06 - charge voltage bit 4 selects 100mV or 200mV recharge offset
// RULE_07 - flag bits hold captured events until the host reads them, then clear
// RULE_08 - undefined register number gets a nack and the target returns idle
// RULE_09 - multi-byte reads and writes step through consecutive registers
// RULE_10 - set mask bit suppresses the int pulse, status and flags still update
// RULE_11 - host writes to read-only status registers are ignored
`timescale 1ns/1ps
`include "chgrb_consts.svh"
module chgrb_bank
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [7:0] loop_status,
  input wire logic [7:0] fault_status,
  output logic int_n,
  output logic temp_window_enable,
  output logic charging_enable,
  output logic timer_enable,
  output logic auto_termination_enable,
  output logic thermal_loop_enable,
  output logic recharge_offset_select,
  output logic [7:0] charge_voltage_setting,
  output logic [7:0] charge_current_setting,
  output logic [7:0] charge_setting_one,
  output logic [7:0] charge_setting_two,
  output logic [7:0] temperature_window_control
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed
  {
    chgrb_pkg::chgrb_state_type fsm;
    logic scl_d;
    logic sda_d;
    logic [2:0] bitn;
    logic full;
    logic [7:0] shift;
    logic rd;
    logic have_ptr;
    logic nack;
    logic [7:0] ptr;
    logic [7:0] tx;
    logic [7:0] sysctl;
    logic [7:0] volt;
    logic [7:0] curr;
    logic [7:0] set1;
    logic [7:0] set2;
    logic [7:0] tempw;
    logic [7:0] mask;
    logic [7:0] flags;
    logic [7:0] fault_d;
    logic sda_drv;
    logic trig;
  } chgrb_bank_type;
  chgrb_bank_type st_reg;
  chgrb_bank_type st_next;
  logic [7:0] rise;
  function automatic logic reg_defined(input logic [7:0] a);
    reg_defined = (a >= `CHGRB_REG_FIRST) && (a <= `CHGRB_REG_LAST);
  endfunction : reg_defined
  function automatic logic [7:0] reg_read(input chgrb_bank_type s, input logic [7:0] a,
    input logic [7:0] lp, input logic [7:0] ft);
    unique case (a[3:0])
      `CHGRB_OFF_SYSCTL: reg_read = s.sysctl;
      `CHGRB_OFF_VOLT: reg_read = s.volt;
      `CHGRB_OFF_CURR: reg_read = s.curr;
      `CHGRB_OFF_SET1: reg_read = s.set1;
      `CHGRB_OFF_SET2: reg_read = s.set2;
      `CHGRB_OFF_TEMPW: reg_read = s.tempw;
      `CHGRB_OFF_LOOP: reg_read = lp;
      `CHGRB_OFF_FAULT: reg_read = ft;
      `CHGRB_OFF_FLAGS: reg_read = s.flags;
      `CHGRB_OFF_MASK: reg_read = s.mask;
      default: reg_read = `CHGRB_ZERO8;
    endcase
  endfunction : reg_read
  // events are rising edges of the live fault status
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_rise
      assign rise[gi] = fault_status[gi] & ~st_reg.fault_d[gi];
    end
  endgenerate
  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    logic start_c;
    logic stop_c;
    logic scl_rise;
    logic scl_fall;
    logic rd_clr;
    logic [7:0] byte_c;
    logic [7:0] rd_c;
    start_c = st_reg.scl_d && scl_in && st_reg.sda_d && !sda_in;
    stop_c = st_reg.scl_d && scl_in && !st_reg.sda_d && sda_in;
    scl_rise = !st_reg.scl_d && scl_in;
    scl_fall = st_reg.scl_d && !scl_in;
    byte_c = {st_reg.shift[6:0], sda_in};
    rd_c = reg_read(st_reg, st_reg.ptr, loop_status, fault_status);
    rd_clr = 1'b0;
    st_next = st_reg;
    st_next.scl_d = scl_in;
    st_next.sda_d = sda_in;
    st_next.fault_d = fault_status;
    if (start_c)
    begin
      st_next.fsm = chgrb_pkg::CHGRB_ADDR;
      st_next.bitn = '0;
      st_next.full = 1'b0;
      st_next.sda_drv = 1'b0;
      st_next.have_ptr = 1'b0;
    end
    else if (stop_c)
    begin
      st_next.fsm = chgrb_pkg::CHGRB_IDLE;
      st_next.sda_drv = 1'b0;
    end
    else
    begin
      unique case (st_reg.fsm)
        chgrb_pkg::CHGRB_IDLE: st_next.sda_drv = 1'b0;
        chgrb_pkg::CHGRB_ADDR, chgrb_pkg::CHGRB_WBYTE:
        begin
          if (scl_rise)
          begin
            st_next.shift = byte_c;
            st_next.bitn = st_reg.bitn + 1'b1;
            st_next.full = (st_reg.bitn == `CHGRB_BYTE_LAST);
          end
          // the fall right after start also sees bitn zero, so only a full byte counts
          if (scl_fall && st_reg.full)
          begin
            // all eight bits taken, decide the acknowledge
            st_next.nack = 1'b0;
            st_next.full = 1'b0;
            if (st_reg.fsm == chgrb_pkg::CHGRB_ADDR)
            begin
              // RULE_01 fixed address match
              if (st_reg.shift[7:1] != `CHGRB_DEV_ADDR)
                st_next.fsm = chgrb_pkg::CHGRB_IDLE;
              else
              begin
                st_next.rd = st_reg.shift[0];
                // RULE_08 read from undefined pointer
                st_next.nack = st_reg.shift[0] && !reg_defined(st_reg.ptr);
                st_next.sda_drv = !(st_reg.shift[0] && !reg_defined(st_reg.ptr));
                st_next.fsm = chgrb_pkg::CHGRB_AACK;
              end
            end
            else
            begin
              st_next.fsm = chgrb_pkg::CHGRB_WACK;
              if (!st_reg.have_ptr)
              begin
                st_next.ptr = st_reg.shift;
                st_next.have_ptr = 1'b1;
                // RULE_08 undefined register number
                st_next.nack = !reg_defined(st_reg.shift);
              end
              else if (!reg_defined(st_reg.ptr))
                st_next.nack = 1'b1;
              else
              begin
                unique case (st_reg.ptr[3:0])
                  `CHGRB_OFF_SYSCTL: st_next.sysctl = st_reg.shift;
                  `CHGRB_OFF_VOLT: st_next.volt = st_reg.shift;
                  `CHGRB_OFF_CURR: st_next.curr = st_reg.shift;
                  `CHGRB_OFF_SET1: st_next.set1 = st_reg.shift;
                  `CHGRB_OFF_SET2: st_next.set2 = st_reg.shift;
                  `CHGRB_OFF_TEMPW: st_next.tempw = st_reg.shift;
                  `CHGRB_OFF_MASK: st_next.mask = st_reg.shift;
                  // RULE_11 status and flag registers take no write
                  default: st_next.ptr = st_reg.ptr;
                endcase
                // RULE_09 step to next register
                st_next.ptr = st_reg.ptr + 1'b1;
              end
              st_next.sda_drv = !st_next.nack;
            end
          end
        end
        chgrb_pkg::CHGRB_AACK, chgrb_pkg::CHGRB_WACK:
        begin
          if (scl_fall)
          begin
            if (st_reg.nack)
            begin
              // RULE_08 back to idle after nack
              st_next.fsm = chgrb_pkg::CHGRB_IDLE;
              st_next.sda_drv = 1'b0;
            end
            else if (st_reg.rd)
            begin
              st_next.tx = rd_c;
              rd_clr = (st_reg.ptr[3:0] == `CHGRB_OFF_FLAGS);
              st_next.ptr = st_reg.ptr + 1'b1;
              st_next.sda_drv = !rd_c[7];
              st_next.bitn = '0;
              st_next.fsm = chgrb_pkg::CHGRB_RBYTE;
            end
            else
            begin
              st_next.sda_drv = 1'b0;
              st_next.bitn = '0;
              st_next.fsm = chgrb_pkg::CHGRB_WBYTE;
            end
          end
        end
        chgrb_pkg::CHGRB_RBYTE:
        begin
          if (scl_fall)
          begin
            if (st_reg.bitn == `CHGRB_BYTE_LAST)
            begin
              st_next.sda_drv = 1'b0;
              st_next.fsm = chgrb_pkg::CHGRB_RACK;
            end
            else
            begin
              st_next.bitn = st_reg.bitn + 1'b1;
              st_next.tx = {st_reg.tx[6:0], 1'b0};
              st_next.sda_drv = !st_reg.tx[6];
            end
          end
        end
        chgrb_pkg::CHGRB_RACK:
        begin
          // RULE_09 master ack asks for the next register
          if (scl_rise)
          begin
            st_next.nack = sda_in || !reg_defined(st_reg.ptr);
            st_next.fsm = chgrb_pkg::CHGRB_AACK;
          end
        end
        default: st_next.fsm = chgrb_pkg::CHGRB_IDLE;
      endcase
    end
    // RULE_07 sticky until read, a new event wins over the read clear
    st_next.flags = (rd_clr ? `CHGRB_ZERO8 : st_reg.flags) | rise;
    // RULE_10 mask gates only the pulse
    st_next.trig = |(rise & ~st_reg.mask);
  end
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      st_reg <= '0;
      st_reg.scl_d <= 1'b1;
      st_reg.sda_d <= 1'b1;
      st_reg.fsm <= chgrb_pkg::CHGRB_IDLE;
      // RULE_02 RULE_03 RULE_04 RULE_05 power-on enables
      st_reg.sysctl <= `CHGRB_RST_SYSCTL;
      st_reg.volt <= `CHGRB_RST_VOLT;
      st_reg.curr <= `CHGRB_RST_CURR;
      st_reg.set1 <= `CHGRB_RST_SET1;
      st_reg.set2 <= `CHGRB_RST_SET2;
      st_reg.tempw <= `CHGRB_RST_TEMPW;
      st_reg.mask <= `CHGRB_RST_MASK;
    end
    else if (clk_en)
      st_reg <= st_next;
  end
  chgrb_int_pulse u_int
  (
    .mclk(mclk),
    .srst(srst),
    .clk_en(clk_en),
    .trig(st_reg.trig),
    .int_n(int_n)
  );
  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign sda_out = 1'b0;
  assign sda_oe = st_reg.sda_drv;
  // RULE_02 charging gate
  assign charging_enable = st_reg.sysctl[`CHGRB_BIT_CHG];
  // RULE_03 safety timer gate
  assign timer_enable = st_reg.sysctl[`CHGRB_BIT_TIMER];
  // RULE_04 termination select
  assign auto_termination_enable = st_reg.sysctl[`CHGRB_BIT_TERM];
  // RULE_05 thermal loop gate
  assign thermal_loop_enable = st_reg.sysctl[`CHGRB_BIT_TLOOP];
  assign temp_window_enable = st_reg.sysctl[`CHGRB_BIT_TWIN];
  // RULE_06 recharge offset select
  assign recharge_offset_select = st_reg.volt[`CHGRB_BIT_RECHG];
  assign charge_voltage_setting = st_reg.volt;
  assign charge_current_setting = st_reg.curr;
  assign charge_setting_one = st_reg.set1;
  assign charge_setting_two = st_reg.set2;
  assign temperature_window_control = st_reg.tempw;
  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_flag_event(int b);
    clk_en && rise[b];
  endsequence
  a_flag_capture: assert property (@(posedge mclk) disable iff (srst) // RULE_07
    s_flag_event(3) |=> st_reg.flags[3])
    else $error("flag not captured");
  a_flag_hold: assert property (@(posedge mclk) disable iff (srst) // RULE_07
    (clk_en && st_reg.fsm == chgrb_pkg::CHGRB_IDLE && $past(st_reg.fsm)
      == chgrb_pkg::CHGRB_IDLE && st_reg.flags[3]) |=> st_reg.flags[3])
    else $error("flag lost without read");
  a_mask_block: assert property (@(posedge mclk) disable iff (srst) // RULE_10
    (clk_en && (rise & ~st_reg.mask) == '0) |=> !st_reg.trig)
    else $error("masked event pulsed int");
  a_unmask_pulse: assert property (@(posedge mclk) disable iff (srst) // RULE_10
    (clk_en && (rise & ~st_reg.mask) != '0) |=> st_reg.trig ##1 !int_n)
    else $error("unmasked event gave no pulse");
  a_nack_idle: assert property (@(posedge mclk) disable iff (srst) // RULE_08
    (clk_en && st_reg.nack && st_reg.fsm == chgrb_pkg::CHGRB_WACK && !scl_in
      && st_reg.scl_d && !(st_reg.scl_d && scl_in)) |=> st_reg.fsm == chgrb_pkg::CHGRB_IDLE)
    else $error("nack did not return idle");
  a_nack_release: assert property (@(posedge mclk) disable iff (srst) // RULE_08
    (st_reg.fsm == chgrb_pkg::CHGRB_WACK && st_reg.nack) |-> !sda_oe)
    else $error("sda driven during nack");
  a_sysctl_hold: assert property (@(posedge mclk) disable iff (srst) // RULE_02
    (st_reg.fsm == chgrb_pkg::CHGRB_IDLE) |=> $stable(charging_enable))
    else $error("charging enable changed outside a write");
  a_idle_quiet: assert property (@(posedge mclk) disable iff (srst) // RULE_01
    (st_reg.fsm == chgrb_pkg::CHGRB_IDLE) |-> !sda_oe)
    else $error("sda driven while idle");
endmodule : chgrb_bank

// file: chgrb_host.sv
// chgrb_host.sv: i2c host model, bus master in front of the register bank
// assumes: scl and sda pulled up, the bank pulls sda low while sda_oe is high
`timescale 1ns/1ps
module chgrb_host
(
  input wire logic mclk,
  input wire logic sda_oe,
  input wire logic sda_out,
  output logic scl,
  output logic sda
);
  logic sda_drv;
  // wired-and with pull-up: a released line reads high, never the last value
  assign sda = sda_drv & ~(sda_oe & ~sda_out);
  initial
  begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // ----------------------------------------
  // bit and byte cycles
  // ----------------------------------------
  // four mclk per scl phase keeps clear of the bank's two-sample minimum
  task automatic half;
    repeat (4) @(negedge mclk);
  endtask : half
  task automatic put_bit(input logic b);
    @(negedge mclk);
    sda_drv = b;
    half();
    scl = 1'b1;
    half();
    scl = 1'b0;
  endtask : put_bit
  task automatic get_bit(output logic b);
    @(negedge mclk);
    sda_drv = 1'b1;
    half();
    scl = 1'b1;
    half();
    b = sda;
    scl = 1'b0;
  endtask : get_bit
  task automatic start;
    @(negedge mclk);
    sda_drv = 1'b1;
    half();
    scl = 1'b1;
    half();
    sda_drv = 1'b0;
    half();
    scl = 1'b0;
  endtask : start
  task automatic stop;
    @(negedge mclk);
    sda_drv = 1'b0;
    half();
    scl = 1'b1;
    half();
    sda_drv = 1'b1;
    half();
  endtask : stop
  task automatic send(input logic [7:0] d, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--)
      put_bit(d[i]);
    get_bit(a);
    ack = ~a;
  endtask : send
  task automatic recv(input logic last, output logic [7:0] d);
    for (int i = 7; i >= 0; i--)
      get_bit(d[i]);
    put_bit(last);
  endtask : recv
  task automatic addr(input logic rd, output logic ack);
    send({7'h69, rd}, ack);
  endtask : addr
endmodule : chgrb_host

// file: test_chgrb_bank.sv
// test_chgrb_bank.sv: self-checking bench of the register bank over i2c
// assumes: the host model is the only master, clk_en held high except low during the frozen-bank write
`timescale 1ns/1ps
module test_chgrb_bank;
  logic mclk;
  logic srst;
  logic clk_en;
  logic scl;
  logic sda;
  logic sda_out;
  logic sda_oe;
  logic int_n;
  logic [7:0] loop_status;
  logic [7:0] fault_status;
  // en[2] carries recharge_offset_select so one byte compares all enables
  logic [5:0] en;
  logic [7:0] reg_out [2:6];
  logic [7:0] tx [0:9];
  logic [7:0] rx [0:9];
  logic [7:0] acks;
  logic ack;
  logic low;
  int cnt;
  int fails;
  int check_count;
  localparam logic [7:0] RST_TAB [0:9] = '{8'h3b, 8'h01, 8'h4a, 8'h0a, 8'h55, 8'h97,
    8'h5a, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] CTL_TAB [0:1] = '{8'hc4, 8'h3b};
  localparam logic [7:0] VLT_TAB [0:1] = '{8'h10, 8'h01};
  chgrb_host host
  (
    .mclk(mclk),
    .sda_oe(sda_oe),
    .sda_out(sda_out),
    .scl(scl),
    .sda(sda)
  );
  chgrb_bank uut
  (
    .mclk(mclk),
    .srst(srst),
    .clk_en(clk_en),
    .scl_in(scl),
    .sda_in(sda),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .loop_status(loop_status),
    .fault_status(fault_status),
    .int_n(int_n),
    .temp_window_enable(en[5]),
    .charging_enable(en[4]),
    .timer_enable(en[3]),
    .auto_termination_enable(en[1]),
    .thermal_loop_enable(en[0]),
    .recharge_offset_select(en[2]),
    .charge_voltage_setting(reg_out[2]),
    .charge_current_setting(reg_out[3]),
    .charge_setting_one(reg_out[4]),
    .charge_setting_two(reg_out[5]),
    .temperature_window_control(reg_out[6])
  );
  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // ----------------------------------------
  // compare, bus transfers, verdict
  // ----------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // acks bit 0 is the pointer byte, bit i+1 the data byte i
  task automatic write_regs(input logic [7:0] r, input int n);
    acks = 8'h00;
    host.start();
    host.addr(1'b0, ack);
    check({7'h00, ack}, 8'h01);
    host.send(r, acks[0]);
    for (int i = 0; i < n; i++)
      host.send(tx[i], acks[i + 1]);
    host.stop();
  endtask : write_regs
  task automatic read_regs(input logic [7:0] r, input int n);
    host.start();
    host.addr(1'b0, ack);
    host.send(r, ack);
    host.start();
    host.addr(1'b1, ack);
    check({7'h00, ack}, 8'h01);
    for (int i = 0; i < n; i++)
      host.recv(i == n - 1, rx[i]);
    host.stop();
  endtask : read_regs
  task automatic summarize;
    if (fails == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  initial
  begin
    repeat (90000) @(negedge mclk);
    fails++;
    summarize();
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial
  begin
    fails = 0;
    check_count = 0;
    srst = 1'b1;
    clk_en = 1'b1;
    loop_status = 8'h5a;
    fault_status = 8'h00;
    repeat (16) @(negedge mclk);
    srst = 1'b0;
    repeat (4) @(negedge mclk);
    // power-on contents through one ten-byte read
    read_regs(8'h01, 10);
    for (int i = 0; i < 10; i++)
      check(rx[i], RST_TAB[i]);
    check({2'b00, en}, 8'h3b);
    for (int i = 2; i < 7; i++)
      check(reg_out[i], RST_TAB[i - 1]);
    // every enable cleared, then set again, with the recharge offset toggled
    for (int k = 0; k < 2; k++)
    begin
      tx[0] = CTL_TAB[k];
      tx[1] = VLT_TAB[k];
      tx[2] = 8'ha5 ^ CTL_TAB[k];
      write_regs(8'h01, 3);
      check(acks, 8'h0f);
      check({2'b00, en}, {2'b00, CTL_TAB[k][5:3], VLT_TAB[k][4],
        CTL_TAB[k][1:0]});
      check(reg_out[3], 8'ha5 ^ CTL_TAB[k]);
      read_regs(8'h01, 3);
      check(rx[0], CTL_TAB[k]);
      check(rx[1], VLT_TAB[k]);
    end
    // writes to the live status places are acked and dropped
    tx[0] = 8'hff;
    tx[1] = 8'hff;
    write_regs(8'h07, 2);
    check(acks, 8'h07);
    read_regs(8'h07, 2);
    check(rx[0], 8'h5a);
    check(rx[1], 8'h00);
    // undefined pointers and stepping past the last register
    write_regs(8'h0b, 0);
    check(acks, 8'h00);
    write_regs(8'h00, 0);
    check(acks, 8'h00);
    tx[0] = 8'h00;
    tx[1] = 8'h77;
    write_regs(8'h0a, 2);
    check(acks, 8'h03);
    host.start();
    host.send(8'hd4, ack);
    host.stop();
    check({7'h00, ack}, 8'h00);
    // frozen bank answers nothing and keeps its enables through a whole write
    clk_en = 1'b0;
    acks = 8'h00;
    host.start();
    host.addr(1'b0, ack);
    host.send(8'h01, acks[0]);
    host.send(8'h00, acks[1]);
    host.stop();
    clk_en = 1'b1;
    check(acks | {7'h00, ack}, 8'h00);
    check({2'b00, en}, 8'h3b);
    // unmasked event: pulse on int_n, flag held until read, then cleared
    fault_status = 8'h08;
    repeat (5) @(negedge mclk);
    check({7'h00, int_n}, 8'h00);
    cnt = 0;
    while (int_n === 1'b0 && cnt < 12000)
    begin
      @(negedge mclk);
      cnt++;
    end
    check({7'h00, cnt >= 11390 && cnt <= 11405}, 8'h01);
    read_regs(8'h08, 2);
    check(rx[0], 8'h08);
    check(rx[1], 8'h08);
    read_regs(8'h09, 1);
    check(rx[0], 8'h00);
    // masked event: no pulse, flag still captured
    tx[0] = 8'h08;
    write_regs(8'h0a, 1);
    fault_status = 8'h00;
    repeat (4) @(negedge mclk);
    fault_status = 8'h08;
    low = 1'b0;
    repeat (30) @(negedge mclk) low = low | ~int_n;
    check({7'h00, low}, 8'h00);
    read_regs(8'h09, 1);
    check(rx[0], 8'h08);
    summarize();
  end
endmodule : test_chgrb_bank
